// ---- logic/ifr_regs.sv ----
/*
 * Interrupt request flag, enable and pin-edge register set with APB slave.
 * Assumes the core pulses SERVICE_IN with a source index when it takes a
 * vector; event sources pulse one-cycle requests in SYS_CLK_IN's domain.
 */
// Functional notes
// - Edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// - Edge register: pin 1 field bits 3:2, pin 0 field bits 1:0.
// - Two-pin edge register: bits 7:4 unimplemented, read zero.
// - Four-pin edge register: pin 3 bits 7:6, pin 2 bits 5:4.
// - Control 0 bit 0 is read/write global interrupt enable.
// - Each flag reads one while pending; software reads and writes it.
// - Per-source enable gates its source, separate from the flag.
// - Small control 0: cmp0, pin1, pin0 flags 6:4, enables 3:1, bit 7 zero.
// - Largest control 0: pin-2 pair replaces comparator-0 pair.
// - Small control 1: converter, mf1, mf0, cmp1 flags 7:4, enables 3:0.
// - Largest control 1: mf0, cmp1, cmp0, pin3 flags 7:4, enables 3:0.
// - Small control 2: mf3, tb1, tb0, mf2 flags 7:4, enables 3:0.
// - Largest control 2: converter, mf3, mf2, mf1 flags 7:4, enables 3:0.
// - Largest only control 3: mf5, tb1, tb0, mf4 flags, enables 3:0.
// - Smallest timer group: t0 A/P flags 5:4, enables 1:0, rest zero.
// - Larger timer group adds t2 A/P flags 7:6, enables 3:2.
// - Request needs own enable and global enable; flags still record.
// - Servicing any interrupt clears the global enable.
// - Servicing an external pin interrupt clears that pin's flag.
`default_nettype none
module ifr_regs
	import ifr_pkg::*;
#(
	parameter logic [1:0] VARIANT = 2'h2
) (
	input wire logic SYS_CLK_IN,
	input wire logic RESET_IN,
	input wire ifr_pkg::ifr_apb_req_t APB_REQ_IN,
	output logic [31:0] APB_PRDATA_OUT,
	output logic APB_PREADY_OUT,
	output logic APB_PSLVERR_OUT,
	input wire logic [3:0] EXT_IRQ_PIN_IN,
	input wire logic [23:0] SRC_EVENT_IN,
	input wire logic SERVICE_IN,
	input wire logic [4:0] SERVICE_IDX_IN,
	output logic IRQ_REQ_OUT,
	output logic [4:0] IRQ_IDX_OUT
);
	import ifr_pkg::*;

	// Internal flat source list, index = logical source
	// 0..3 pins, 4 cmp0, 5 cmp1, 6 conv, 7..12 mf0..mf5, 13 tb0, 14 tb1,
	// 15 t0P, 16 t0A, 17 t2P, 18 t2A
	localparam int NSRC = 19;
	// Smaller parts: pins 2..3 and mf4..mf5 absent; t2 pair kept for the mid part
	localparam logic [18:0] IMPL_SMALL = 19'h7FFFF & ~19'h0180C;
	localparam logic [18:0] IMPL_BIG = 19'h7FFFF;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [7:0] edge_cfg;
		logic gie;
		logic [NSRC-1:0] flag;
		logic [NSRC-1:0] en;
		ifr_bus_st_t bus;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
		logic [4:0] idx;
	} ifr_state_t;

	ifr_state_t st, next_st;

	////////////////////////////////////////////////////////////////////////
	// Bit map functions: register byte from flat vectors and back

	function automatic logic [NSRC-1:0] impl_mask(input logic [1:0] v);
		logic [NSRC-1:0] m;
		m = (v == VAR_LARGEST) ? IMPL_BIG : IMPL_SMALL;
		if (v == VAR_SMALLEST) begin
			m[17] = 1'b0;
			m[18] = 1'b0;
		end
		return m;
	endfunction

	// Source indices of the four flag/enable slots, bit 7..4 order
	function automatic logic [19:0] slot_map(input logic [7:0] off,
		input logic [1:0] v);
		logic big;
		big = (v == VAR_LARGEST);
		slot_map = {5'd31, 5'd31, 5'd31, 5'd31};
		unique case (off)
			OFF_CTRL0: slot_map = {5'd31, big ? 5'd2 : 5'd4, 5'd1, 5'd0};
			OFF_CTRL1: slot_map = big ? {5'd7, 5'd5, 5'd4, 5'd3} :
				{5'd6, 5'd8, 5'd7, 5'd5};
			OFF_CTRL2: slot_map = big ? {5'd6, 5'd10, 5'd9, 5'd8} :
				{5'd10, 5'd14, 5'd13, 5'd9};
			OFF_CTRL3: slot_map = big ? {5'd12, 5'd14, 5'd13, 5'd11} :
				{5'd31, 5'd31, 5'd31, 5'd31};
			OFF_TMR0: slot_map = {5'd18, 5'd17, 5'd16, 5'd15};
			default: slot_map = {5'd31, 5'd31, 5'd31, 5'd31};
		endcase
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
		input logic cur);
		unique case (sel)
			EDGE_OFF: edge_hit = 1'b0;
			EDGE_RISE: edge_hit = !prev && cur;
			EDGE_FALL: edge_hit = prev && !cur;
			EDGE_BOTH: edge_hit = prev != cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic [NSRC-1:0] impl;
	logic [NSRC-1:0] set_ev;
	logic [19:0] smap;
	logic [7:0] rbyte;
	logic [4:0] s;
	logic wr_acc;
	logic rd_acc;
	logic known;
	logic [NSRC-1:0] pend;

	always_comb begin
		impl = impl_mask(VARIANT);
		next_st = st;
		set_ev = '0;
		rbyte = REG_RESET;
		s = 5'd0;
		pend = '0;
		smap = slot_map(APB_REQ_IN.paddr, VARIANT);
		known = (APB_REQ_IN.paddr == OFF_EDGE) || (APB_REQ_IN.paddr == OFF_CTRL0) ||
			(APB_REQ_IN.paddr == OFF_CTRL1) || (APB_REQ_IN.paddr == OFF_CTRL2) ||
			(APB_REQ_IN.paddr == OFF_TMR0) || (APB_REQ_IN.paddr == OFF_STAT) ||
			(APB_REQ_IN.paddr == OFF_ACK) ||
			(APB_REQ_IN.paddr == OFF_CTRL3 && VARIANT == VAR_LARGEST);
		wr_acc = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite &&
			st.bus == ST_ACCESS && known;
		rd_acc = APB_REQ_IN.psel && !APB_REQ_IN.pwrite && known;

		next_st.sync1 = EXT_IRQ_PIN_IN;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;

		for (int p = 0; p < 4; p++) begin
			set_ev[p] = edge_hit(st.edge_cfg[2*p +: 2], st.sync3[p], st.sync2[p]);
		end
		set_ev[NSRC-1:4] = SRC_EVENT_IN[NSRC-5:0];
		set_ev = set_ev & impl;

		// Bus handshake: one wait state, answer in the second access cycle
		next_st.ready = 1'b0;
		next_st.err = 1'b0;
		unique case (st.bus)
			ST_IDLE: begin
				if (APB_REQ_IN.psel && APB_REQ_IN.penable) begin
					next_st.bus = ST_ACCESS;
					next_st.ready = 1'b1;
					next_st.err = !known;
				end
			end
			ST_ACCESS: next_st.bus = ST_IDLE;
		endcase

		// Software writes
		if (wr_acc) begin
			unique case (APB_REQ_IN.paddr)
				OFF_EDGE: next_st.edge_cfg = (VARIANT == VAR_LARGEST) ?
					APB_REQ_IN.pwdata[7:0] : {4'h0, APB_REQ_IN.pwdata[3:0]};
				OFF_STAT, OFF_ACK: ;
				default: begin
					if (APB_REQ_IN.paddr == OFF_CTRL0) begin
						next_st.gie = APB_REQ_IN.pwdata[GIE_BIT];
					end
					for (int k = 0; k < 4; k++) begin
						s = smap[5*k +: 5];
						if (s < 5'(NSRC) && impl[s]) begin
							next_st.flag[s] = APB_REQ_IN.pwdata[FLAG_LSB + k];
							// Control 0 enables sit one bit up, above the global enable
							next_st.en[s] =
								APB_REQ_IN.pwdata[k + int'(APB_REQ_IN.paddr == OFF_CTRL0)];
						end
					end
				end
			endcase
		end

		// pend needs own enable; request also needs global enable
		pend = st.flag & st.en & impl;
		next_st.irq = st.gie && (pend != '0) && !SERVICE_IN;
		next_st.idx = 5'd0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				next_st.idx = 5'(i);
			end
		end

		if (SERVICE_IN) begin
			next_st.gie = 1'b0;
			if (SERVICE_IDX_IN < 5'd4) begin
				next_st.flag[SERVICE_IDX_IN] = 1'b0;
			end
		end

		// hardware set wins over software and service clears; reset still clears
		next_st.flag = next_st.flag | set_ev;

		// Read data assembly
		if (APB_REQ_IN.paddr == OFF_EDGE) begin
			rbyte = st.edge_cfg;
		end else if (APB_REQ_IN.paddr == OFF_STAT) begin
			rbyte = {2'h0, st.irq, st.idx};
		end else begin
			for (int k = 0; k < 4; k++) begin
				s = smap[5*k +: 5];
				if (s < 5'(NSRC) && impl[s]) begin
					rbyte[FLAG_LSB + k] = st.flag[s];
					rbyte[k + int'(APB_REQ_IN.paddr == OFF_CTRL0)] = st.en[s];
				end
			end
			if (APB_REQ_IN.paddr == OFF_CTRL0) begin
				rbyte[GIE_BIT] = st.gie;
			end
		end
		next_st.rdata = (rd_acc && st.bus == ST_IDLE) ? {24'h0, rbyte} : 32'h0;

		if (RESET_IN) begin
			next_st = '0;
			next_st.bus = ST_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		st <= next_st;
	end

	assign APB_PRDATA_OUT = st.rdata;
	assign APB_PREADY_OUT = st.ready;
	assign APB_PSLVERR_OUT = st.err;
	assign IRQ_REQ_OUT = st.irq;
	assign IRQ_IDX_OUT = st.idx;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	gie_clear_srv_a: assert property (SERVICE_IN |=> !st.gie)
		else $error("global enable survived service");
	irq_needs_gie_a: assert property (IRQ_REQ_OUT |-> $past(st.gie))
		else $error("request without global enable");
	irq_needs_en_a: assert property (IRQ_REQ_OUT |-> $past(st.en[IRQ_IDX_OUT]))
		else $error("request without source enable");
	pin_rise_set_a: assert property ((st.edge_cfg[1:0] == EDGE_RISE && !st.sync3[0]
		&& st.sync2[0]) |=> st.flag[0])
		else $error("rising edge missed");
	pin_off_quiet_a: assert property ((st.edge_cfg[1:0] == EDGE_OFF && !$past(st.flag[0])
		&& !$past(wr_acc)) |-> !st.flag[0] || $past(wr_acc))
		else $error("disabled pin raised flag");
	pin_srv_clr_a: assert property ((SERVICE_IN && SERVICE_IDX_IN == 5'd1 && !set_ev[1])
		|=> !st.flag[1])
		else $error("pin flag not cleared");
	edge_hi_zero_a: assert property ((VARIANT != VAR_LARGEST) |-> st.edge_cfg[7:4] == 4'h0)
		else $error("unimplemented edge bits set");
	flag_record_a: assert property ((!st.gie && SRC_EVENT_IN[0]) |=> st.flag[4])
		else $error("flag not recorded");
	rd_ready_a: assert property ((APB_REQ_IN.psel && APB_REQ_IN.penable && !st.ready)
		|-> ##[1:2] st.ready)
		else $error("bus answer late");

	srv_cov_c: cover property (SERVICE_IN ##1 !st.gie);
	irq_cov_c: cover property (IRQ_REQ_OUT);
	both_edge_c: cover property (st.edge_cfg[1:0] == EDGE_BOTH && set_ev[0]);
endmodule
`default_nettype wire

// ---- include/ifr_pkg.sv ----
/*
 * Package for the interrupt flag, enable and edge register block: register
 * offsets, field positions, reset values, edge encodings and state types.
 * Assumes a 32-bit APB with word-aligned 8-bit registers in the low bits.
 */
`default_nettype none
package ifr_pkg;
	// Register byte offsets (no offsets printed; chosen here)
	localparam logic [7:0] OFF_EDGE = 8'h00;
	localparam logic [7:0] OFF_CTRL0 = 8'h04;
	localparam logic [7:0] OFF_CTRL1 = 8'h08;
	localparam logic [7:0] OFF_CTRL2 = 8'h0C;
	localparam logic [7:0] OFF_CTRL3 = 8'h10;
	localparam logic [7:0] OFF_TMR0 = 8'h14;
	localparam logic [7:0] OFF_ACK = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1C;
	// Register reset value
	localparam logic [7:0] REG_RESET = 8'h00;
	// Flag half sits above enable half in every control register
	localparam int FLAG_LSB = 4;
	localparam int GIE_BIT = 0;
	localparam int PIN1_FIELD_LSB = 2;
	localparam int PIN2_FIELD_LSB = 4;
	localparam int PIN3_FIELD_LSB = 6;
	// Edge field encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Variant codes
	localparam logic [1:0] VAR_SMALLEST = 2'h0;
	localparam logic [1:0] VAR_MID = 2'h1;
	localparam logic [1:0] VAR_LARGEST = 2'h2;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ifr_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ifr_apb_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS
	} ifr_bus_st_t;
endpackage
`default_nettype wire

// ---- bench/ifr_core_model.sv ----
/*
 * Core model: takes a vector while the block requests one.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module ifr_core_model #(
	parameter int DELAY = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic irq_in,
	input wire logic [4:0] idx_in,
	output logic svc_out,
	output logic [4:0] svc_idx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// Waits DELAY cycles of a standing request, like a core finishing an instruction
	always_ff @(posedge clk_in) begin
		svc_out <= 1'b0;
		svc_idx_out <= ~svc_idx_out;
		if (rst_in) begin
			svc_idx_out <= 5'h0A;
			cnt <= 0;
		end else if (!irq_in || svc_out) begin
			cnt <= 0;
		end else if (cnt == DELAY) begin
			svc_out <= 1'b1;
			svc_idx_out <= idx_in;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/test_irq_flag_enable_edge_regs.sv ----
/*
 * Testbench for the interrupt flag/enable/edge registers, largest variant.
 * Assumes the core model in its own file and the package in the include path.
 */
`default_nettype none
module test_irq_flag_enable_edge_regs;
	import ifr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic svc, pready, pslverr, irq;
	ifr_apb_req_t req = '0;
	logic [31:0] prdata;
	logic [3:0] pins = 4'h0;
	logic [23:0] ev = 24'h0;
	logic [4:0] idx, svc_idx;
	int failures = 0;
	int tests_run = 0;
	int seed = 32'h0556;
	int cyc = 0;
	logic [7:0] mask [6] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	ifr_regs #(.VARIANT(VAR_LARGEST)) i_dut (
		.SYS_CLK_IN(sys_clk), .RESET_IN(rst), .APB_REQ_IN(req),
		.APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready), .APB_PSLVERR_OUT(pslverr),
		.EXT_IRQ_PIN_IN(pins), .SRC_EVENT_IN(ev), .SERVICE_IN(svc),
		.SERVICE_IDX_IN(svc_idx), .IRQ_REQ_OUT(irq), .IRQ_IDX_OUT(idx));
	ifr_core_model #(.DELAY(2)) i_core (.clk_in(sys_clk), .rst_in(rst), .irq_in(irq),
		.idx_in(idx), .svc_out(svc), .svc_idx_out(svc_idx));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("tests %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Holds the request until pready is sampled high or 20 cycles pass
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", {31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r, {24'h0, exp});
	endtask
	task automatic waitirq(input logic lvl);
		int n;
		n = 0;
		while (irq !== lvl && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq", {31'h0, irq}, {31'h0, lvl});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic e;
		logic [7:0] a, d, fl;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) rdc("reset", 8'(4 * i), 8'h00);
		apb(1'b1, 8'h20, 32'h0, r, e);
		chk("unmapped", {31'h0, e}, 32'h1);
		$display("test reset done");
		// Global enable kept off so random flags cannot be serviced
		for (int k = 0; k < 18; k++) begin
			a = 8'(4 * (k % 6));
			d = 8'($random(seed)) & ~8'(a == OFF_CTRL0);
			wr(a, d);
			rdc("layout", a, d & mask[k % 6]);
		end
		for (int i = 0; i < 6; i++) wr(8'(4 * i), 8'h00);
		$display("test layout done");
		// every edge mode on every pin
		for (int p = 0; p < 4; p++) begin
			a = (p == 3) ? OFF_CTRL1 : OFF_CTRL0;
			fl = (p == 3) ? 8'h10 : 8'(8'h10 << p);
			for (int m = 0; m < 4; m++) begin
				wr(OFF_EDGE, 8'(m << (2 * p)));
				pins[p] <= 1'b1;
				repeat (8) @(posedge sys_clk);
				rdc("rise", a, m[0] ? fl : 8'h00);
				pins[p] <= 1'b0;
				repeat (8) @(posedge sys_clk);
				rdc("fall", a, (m != 0) ? fl : 8'h00);
				wr(a, 8'h00);
			end
		end
		$display("test edges done");
		// event recorded while gated, then serviced
		wr(OFF_CTRL1, 8'h08);
		ev[3] <= 1'b1;
		@(posedge sys_clk);
		ev[3] <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk("gated", {31'h0, irq}, 32'h0);
		rdc("recorded", OFF_CTRL1, 8'h88);
		wr(OFF_CTRL0, 8'h01);
		waitirq(1'b1);
		chk("index", {27'h0, idx}, 32'h7);
		waitirq(1'b0);
		rdc("gie clear", OFF_CTRL0, 8'h00);
		rdc("flag kept", OFF_CTRL1, 8'h88);
		wr(OFF_CTRL1, 8'h00);
		wr(OFF_EDGE, 8'h01);
		wr(OFF_CTRL0, 8'h03);
		pins[0] <= 1'b1;
		waitirq(1'b1);
		chk("pin index", {27'h0, idx}, 32'h0);
		waitirq(1'b0);
		rdc("pin serviced", OFF_CTRL0, 8'h02);
		$display("test service done");
		final_report();
	end
endmodule
`default_nettype wire
